// [shared/drf_pkg.sv]
// package: constants and types for the dram refresh and self-refresh block
package drf_pkg;
  // ****************************************************************
  // command decode widths and burst codes
  // ****************************************************************
  localparam int ROW_W = 16;
  localparam int BANKS = 8;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_CHOP4 = 2'h2;
  localparam logic [3:0] BEATS_8 = 4'h8;
  localparam logic [3:0] BEATS_4 = 4'h4;
  localparam int OTF_BIT = 12;
  localparam int DLL_EN_BIT = 0;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ = 50;
  localparam int TCKE_NS = 5000;
  localparam int TCKE_CYC = (TCKE_NS * CLK_MHZ) / 1000;
  localparam int TREFI_NS = 7800;
  localparam int TREFI_CYC = (TREFI_NS * CLK_MHZ) / 1000;
  localparam int TDLLK_CYC = 512;
  localparam logic [ROW_W-1:0] ROW_RST = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REFRESH,
    ST_SELF
  } drf_state_type;
endpackage

// [shared/drf_cnt_if.sv]
// interface: internal refresh row counter link
`timescale 1ns/1ps
interface drf_cnt_if #(parameter int ROW_W = 16);
  logic step;
  logic [ROW_W-1:0] row;
  modport ctl (output step, input row);
  modport cnt (input step, output row);
endinterface

// [verilog/drf_row_counter.sv]
// module: internal refresh row address counter
`timescale 1ns/1ps
module drf_row_counter #(
  parameter int ROW_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  drf_cnt_if.cnt link
);
  import drf_pkg::*;
  logic [ROW_W-1:0] row_r;
  logic [ROW_W-1:0] row_nxt;

  always_comb begin
    row_nxt = row_r;
    if (link.step) begin
      row_nxt = row_r + {{(ROW_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      row_r <= '0;
    end else begin
      row_r <= row_nxt;
    end
  end

  assign link.row = row_r;
endmodule

// [verilog/drf_refresh_ctl.sv]
// module: device-side refresh, self-refresh and write burst length logic
`timescale 1ns/1ps
// Operation
// - refresh decoded: cs ras cas low, we high
// - refresh uses internal row counter, banks idle
// - self-refresh entry decoded with cke low
// - self-refresh held while cke low
// - dll off on entry, reset on exit
// - internal refresh within tCKE, then timer
// - burst length from mode bits A[1:0]
// - A12 selects chop4 or eight, not column
module drf_refresh_ctl
  import drf_pkg::*;
#(
  parameter int ROW_W = drf_pkg::ROW_W,
  parameter int TCKE_CYCLES = drf_pkg::TCKE_CYC,
  parameter int TREFI_CYCLES = drf_pkg::TREFI_CYC,
  parameter int TDLL_CYCLES = drf_pkg::TDLLK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cke_pin,
  input wire logic cs_n_pin,
  input wire logic ras_n_pin,
  input wire logic cas_n_pin,
  input wire logic we_n_pin,
  input wire logic a12_pin,
  input wire logic [1:0] mr0_bl,
  input wire logic mr1_dll_dis,
  output logic self_refresh,
  output logic refresh_busy,
  output logic banks_idle,
  output logic [ROW_W-1:0] refresh_row,
  output logic dll_on,
  output logic dll_locked,
  output logic [3:0] write_beats,
  output logic write_burst_valid
);
  import drf_pkg::*;

  // elaboration check of the timing and width parameters
  if (ROW_W < 1 || TCKE_CYCLES < 2 || TREFI_CYCLES < 2 || TDLL_CYCLES < 1) begin
    $error("drf_refresh_ctl: unsupported parameter values");
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic cke_prev_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_r <= 6'h3E;
      pin_s2_r <= 6'h3E;
      cke_prev_r <= 1'b0;
    end else begin
      pin_s1_r <= {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, a12_pin, cke_pin};
      pin_s2_r <= pin_s1_r;
      cke_prev_r <= pin_s2_r[0];
    end
  end
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic a12;
  logic cke;
  assign {cs_n, ras_n, cas_n, we_n, a12, cke} = pin_s2_r;

  // ****************************************************************
  // command decode
  // ****************************************************************
  function automatic logic is_ref_code(input logic c, input logic r, input logic a,
                                       input logic w);
    return !c && !r && !a && w;
  endfunction

  logic ref_cmd;
  logic sre_cmd;
  logic wr_cmd;
  assign ref_cmd = cke_prev_r && cke && is_ref_code(cs_n, ras_n, cas_n, we_n);
  assign sre_cmd = cke_prev_r && !cke && is_ref_code(cs_n, ras_n, cas_n, we_n);
  assign wr_cmd = cke_prev_r && cke && !cs_n && ras_n && !cas_n && !we_n;

  // ****************************************************************
  // refresh and self-refresh sequencer
  // ****************************************************************
  localparam int CW = $clog2(TCKE_CYCLES + TREFI_CYCLES + TDLL_CYCLES + 2);
  localparam logic [CW-1:0] RFC_LAST = CW'(TCKE_CYCLES - 1);
  localparam logic [CW-1:0] CKE_LAST = CW'(TCKE_CYCLES - 1);
  localparam logic [CW-1:0] REFI_LAST = CW'(TREFI_CYCLES - 1);
  localparam logic [CW-1:0] DLL_LAST = CW'(TDLL_CYCLES - 1);

  drf_state_type st_r;
  drf_state_type st_nxt;
  logic [CW-1:0] tmr_r;
  logic [CW-1:0] tmr_nxt;
  logic first_done_r;
  logic first_done_nxt;
  logic dll_on_r;
  logic dll_on_nxt;
  logic dll_auto_r;
  logic dll_auto_nxt;
  logic [CW-1:0] lock_r;
  logic [CW-1:0] lock_nxt;
  logic locked_r;
  logic locked_nxt;
  logic step;

  drf_cnt_if #(.ROW_W(ROW_W)) cnt_link ();
  drf_row_counter #(.ROW_W(ROW_W)) u_rows (
    .clk(clk),
    .nrst(nrst),
    .link(cnt_link)
  );
  assign cnt_link.step = step;

  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    first_done_nxt = first_done_r;
    dll_on_nxt = dll_on_r;
    dll_auto_nxt = dll_auto_r;
    lock_nxt = lock_r;
    locked_nxt = locked_r;
    step = 1'b0;
    if (!locked_r && dll_on_r) begin
      if (lock_r == DLL_LAST) begin
        locked_nxt = 1'b1;
      end else begin
        lock_nxt = lock_r + 1'b1;
      end
    end
    case (st_r)
      ST_IDLE: begin
        if (ref_cmd) begin
          step = 1'b1;
          st_nxt = ST_REFRESH;
          tmr_nxt = '0;
        end else if (sre_cmd) begin
          st_nxt = ST_SELF;
          tmr_nxt = '0;
          first_done_nxt = 1'b0;
          if (!mr1_dll_dis) begin
            dll_on_nxt = 1'b0;
            dll_auto_nxt = 1'b1;
            locked_nxt = 1'b0;
          end
        end
      end
      ST_REFRESH: begin
        if (tmr_r == RFC_LAST) begin
          st_nxt = ST_IDLE;
        end else begin
          tmr_nxt = tmr_r + 1'b1;
        end
      end
      ST_SELF: begin
        if ((!first_done_r && tmr_r == CKE_LAST) || (first_done_r && tmr_r == REFI_LAST)) begin
          step = 1'b1;
          first_done_nxt = 1'b1;
          tmr_nxt = '0;
        end else begin
          tmr_nxt = tmr_r + 1'b1;
        end
        if (cke) begin
          st_nxt = ST_IDLE;
          if (dll_auto_r) begin
            dll_on_nxt = 1'b1;
            dll_auto_nxt = 1'b0;
            lock_nxt = '0;
            locked_nxt = 1'b0;
          end
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (mr1_dll_dis && st_r != ST_SELF) begin
      dll_on_nxt = 1'b0;
      locked_nxt = 1'b0;
    end else if (!mr1_dll_dis && !dll_on_r && st_r != ST_SELF) begin
      dll_on_nxt = 1'b1;
      lock_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      tmr_r <= '0;
      first_done_r <= 1'b0;
      dll_on_r <= 1'b0;
      dll_auto_r <= 1'b0;
      lock_r <= '0;
      locked_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      first_done_r <= first_done_nxt;
      dll_on_r <= dll_on_nxt;
      dll_auto_r <= dll_auto_nxt;
      lock_r <= lock_nxt;
      locked_r <= locked_nxt;
    end
  end

  // ****************************************************************
  // write burst length
  // ****************************************************************
  logic [3:0] beats_r;
  logic [3:0] beats_nxt;
  logic wv_r;
  logic wv_nxt;
  always_comb begin
    beats_nxt = beats_r;
    wv_nxt = 1'b0;
    if (wr_cmd && st_r == ST_IDLE) begin
      wv_nxt = 1'b1;
      case (mr0_bl)
        BL_FIXED8: beats_nxt = BEATS_8;
        BL_OTF: beats_nxt = a12 ? BEATS_8 : BEATS_4;
        BL_CHOP4: beats_nxt = BEATS_4;
        default: beats_nxt = BEATS_8;
      endcase
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      beats_r <= BEATS_8;
      wv_r <= 1'b0;
    end else begin
      beats_r <= beats_nxt;
      wv_r <= wv_nxt;
    end
  end

  assign self_refresh = (st_r == ST_SELF);
  assign refresh_busy = (st_r == ST_REFRESH);
  assign banks_idle = (st_r != ST_REFRESH);
  assign refresh_row = cnt_link.row;
  assign dll_on = dll_on_r;
  assign dll_locked = locked_r;
  assign write_beats = beats_r;
  assign write_burst_valid = wv_r;
endmodule

// [verif/drf_refresh_sva.sv]
// checker: port-level properties of the refresh block
`timescale 1ns/1ps
module drf_refresh_sva
  import drf_pkg::*;
#(
  parameter int ROW_W = 16,
  parameter int TCKE_CYCLES = drf_pkg::TCKE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cke_pin,
  input wire logic cs_n_pin,
  input wire logic ras_n_pin,
  input wire logic cas_n_pin,
  input wire logic we_n_pin,
  input wire logic a12_pin,
  input wire logic [1:0] mr0_bl,
  input wire logic mr1_dll_dis,
  input wire logic self_refresh,
  input wire logic refresh_busy,
  input wire logic banks_idle,
  input wire logic [ROW_W-1:0] refresh_row,
  input wire logic dll_on,
  input wire logic dll_locked,
  input wire logic [3:0] write_beats,
  input wire logic write_burst_valid
);
  // ****
  // properties
  // ****
  localparam int SR_MAX = TCKE_CYCLES + 1;
  localparam int RFC_MAX = TCKE_CYCLES;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_code;
    !cs_n_pin && !ras_n_pin && !cas_n_pin && we_n_pin && $past(cke_pin);
  endsequence
  sequence s_free;
    !refresh_busy && !self_refresh;
  endsequence
  a_ref_decode: assert property (s_code ##0 cke_pin ##2 s_free |=> refresh_busy)
    else $error("refresh not started");
  a_sre_entry: assert property (s_code ##0 !cke_pin ##2 s_free |=> self_refresh && !dll_on)
    else $error("self-refresh entry missed");
  a_self_hold: assert property ((!cke_pin) [*3] ##0 self_refresh |=> self_refresh)
    else $error("self-refresh left with cke low");
  a_self_step: assert property ($rose(self_refresh) |-> ##[1:SR_MAX] refresh_row != $past(refresh_row))
    else $error("no internal refresh after entry");
  a_dll_exit: assert property ($fell(self_refresh) && !mr1_dll_dis |-> ##[0:1] dll_on)
    else $error("dll not back on after exit");
  a_dll_relock: assert property ($rose(dll_on) |-> !dll_locked)
    else $error("dll locked without reset");
  a_row_step: assert property ($rose(refresh_busy) |-> refresh_row == ROW_W'($past(refresh_row) + 1))
    else $error("row counter not stepped");
  a_banks_idle: assert property ($rose(refresh_busy) |-> ##[1:RFC_MAX] banks_idle)
    else $error("banks not idle after refresh");
  a_burst_len: assert property (write_burst_valid |-> write_beats ==
    ((($past(mr0_bl, 3) == BL_CHOP4) || ($past(mr0_bl, 3) == BL_OTF && !$past(a12_pin, 3)))
    ? BEATS_4 : BEATS_8))
    else $error("wrong burst length");
endmodule
bind drf_refresh_ctl drf_refresh_sva #(.ROW_W(ROW_W), .TCKE_CYCLES(TCKE_CYCLES)) u_sva (
  .clk(clk),
  .nrst(nrst),
  .cke_pin(cke_pin),
  .cs_n_pin(cs_n_pin),
  .ras_n_pin(ras_n_pin),
  .cas_n_pin(cas_n_pin),
  .we_n_pin(we_n_pin),
  .a12_pin(a12_pin),
  .mr0_bl(mr0_bl),
  .mr1_dll_dis(mr1_dll_dis),
  .self_refresh(self_refresh),
  .refresh_busy(refresh_busy),
  .banks_idle(banks_idle),
  .refresh_row(refresh_row),
  .dll_on(dll_on),
  .dll_locked(dll_locked),
  .write_beats(write_beats),
  .write_burst_valid(write_burst_valid)
);

// [verif/drf_ctl_model.sv]
// partner: memory controller driving the command pins
`timescale 1ns/1ps
module drf_ctl_model (
  input wire logic clk,
  output logic cke,
  output logic [3:0] cmd_n,
  output logic a12
);
  localparam int REFI = drf_pkg::TREFI_CYC;
  localparam int WR_GAP = 512;
  int now = 0;
  int tick = 0;
  int owed = 0;
  int done = 0;
  int x_at = -WR_GAP;
  int ref_q[$];
  // debt grows per interval, frozen in self-refresh
  always @(posedge clk) begin
    now <= now + 1;
    if (cke) begin
      tick <= (tick == REFI - 1) ? 0 : tick + 1;
      owed <= (tick == REFI - 1) ? owed + 1 : owed;
    end
  end
  initial begin
    cke = 1'b1;
    cmd_n = 4'hF;
    a12 = 1'b0;
  end
  // no row opened, termination never driven
  task automatic issue(input logic [3:0] c, input logic k, input logic a);
    // at most 16 refreshes in two intervals
    while (c == 4'h1 && k && ref_q.size() >= 16 && now - ref_q[0] < 2 * REFI) begin
      @(posedge clk);
    end
    // write late after exit, no read or precharge
    while (c == 4'h4 && k && now - x_at < WR_GAP) begin
      @(posedge clk);
    end
    @(posedge clk);
    if (k && !cke) begin
      x_at = now;
    end
    if (c == 4'h1 && k) begin
      if (ref_q.size() >= 16) begin
        void'(ref_q.pop_front());
      end
      ref_q.push_back(now);
      // no credit past eight pulled in
      if (done < owed + 8) begin
        done = done + 1;
      end
    end
    cmd_n <= c;
    cke <= k;
    a12 <= a;
    @(posedge clk);
    cmd_n <= 4'hF;
    a12 <= ~a;
  endtask
endmodule

// [verif/tb.sv]
// bench: refresh block against a queue-based reference
`timescale 1ns/1ps
module tb;
  import drf_pkg::*;
  localparam int TC = 4;
  localparam int TD = 8;
  logic clk, nrst, cke, a12, dll_dis, wv, sr_on, busy, idle, dll_on, locked, a;
  logic [3:0] cmd_n, beats;
  logic [1:0] bl, b;
  logic [ROW_W-1:0] row, s;
  logic [3:0] q[$];
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int exp_row = 0;
  drf_ctl_model ctl (.clk(clk), .cke(cke), .cmd_n(cmd_n), .a12(a12));
  drf_refresh_ctl #(.TCKE_CYCLES(TC), .TREFI_CYCLES(8), .TDLL_CYCLES(TD)) uut (
    .clk(clk), .nrst(nrst), .cke_pin(cke), .cs_n_pin(cmd_n[3]), .ras_n_pin(cmd_n[2]),
    .cas_n_pin(cmd_n[1]), .we_n_pin(cmd_n[0]), .a12_pin(a12), .mr0_bl(bl),
    .mr1_dll_dis(dll_dis), .self_refresh(sr_on), .refresh_busy(busy), .banks_idle(idle),
    .refresh_row(row), .dll_on(dll_on), .dll_locked(locked), .write_beats(beats),
    .write_burst_valid(wv));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk_flag(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t flag got %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk_row(input logic [ROW_W-1:0] g, input int e);
    checked++;
    if (g !== ROW_W'(e)) begin
      num_errors++;
      $display("[FAIL] %0t row got %h exp %h", $time, g, ROW_W'(e));
    end
  endtask
  task automatic chk_beats(input logic [3:0] g, input logic [3:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t beats got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // second command only after the refresh cycle
  task automatic do_ref(input logic twice, input logic wr);
    for (int k = 0; k < (twice ? 2 : 1); k++) begin
      if (k == 1 && wr) begin
        q.push_back(4'h8);
        ctl.issue(4'h4, 1'b1, 1'b1);
        wait_n(4);
        chk_row(row, exp_row);
      end else begin
        ctl.issue(4'h1, 1'b1, 1'b0);
        wait_n(3);
        exp_row++;
        chk_flag(busy, 1'b1);
        chk_flag(idle, 1'b0);
        chk_row(row, exp_row);
        wait_n(TC + 4);
        chk_row(row, exp_row);
        chk_flag(idle, 1'b1);
      end
    end
  endtask
  task automatic sr(input logic dis);
    @(posedge clk);
    dll_dis <= dis;
    ctl.issue(4'h1, 1'b0, 1'b0);
    // control inputs ignored while cke low
    ctl.issue(4'h4, 1'b0, 1'b1);
    wait_n(1);
    chk_flag(sr_on, 1'b1);
    chk_flag(dll_on, 1'b0);
    s = row;
    wait_n(30);
    chk_flag(row !== s, 1'b1);
    chk_flag(sr_on, 1'b1);
    ctl.issue(4'hF, 1'b1, 1'b0);
    wait_n(4);
    chk_flag(sr_on, 1'b0);
    chk_flag(dll_on, !dis);
    chk_flag(locked, 1'b0);
    // only deselect through the exit interval
    wait_n(TD + 4);
    chk_flag(locked, !dis);
    exp_row = row;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (wv === 1'b1) chk_beats(beats, q.size() ? q.pop_front() : 4'h0);
    if (cyc == 3000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    nrst = 1'b0;
    bl = 2'h0;
    dll_dis = 1'b0;
    void'($urandom(32'hA290BAAE));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    wait_n(3);
    chk_flag(sr_on, 1'b0);
    chk_row(row, 0);
    chk_flag(dll_on, 1'b1);
    do_ref(1'b1, 1'b0);
    do_ref(1'b1, 1'b1);
    for (int i = 0; i < 12; i++) begin
      b = 2'($urandom);
      a = 1'($urandom);
      @(posedge clk);
      bl <= b;
      q.push_back((b == 2'h2 || (b == 2'h1 && !a)) ? 4'h4 : 4'h8);
      ctl.issue(4'h4, 1'b1, a);
      wait_n(4);
    end
    sr(1'b0);
    do_ref(1'b0, 1'b0);
    sr(1'b1);
    chk_flag(q.size() == 0, 1'b1);
    end_sim();
  end
endmodule
